//--- cdde_engine.sv
// chained descriptor engine: scheduler, fetch, push/pull issue, signatures
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps

module cdde_engine
	import cdde_pkg::*;
#(
	parameter int CH_DEPTH   = 8,
	parameter int SIGN_DEPTH = 128
) (
	// clock and reset
	input  logic       clk,
	input  logic       rst_b,
	// register port
	input  cdde_bus_s  bus,
	output logic [31:0] rdata,
	// descriptor fetch from system memory
	output logic       mem_req,
	output logic [31:0] mem_addr,
	input  logic       mem_ack,
	input  logic [63:0] mem_data,
	// memory push segments
	output logic       push_valid,
	output cdde_push_s push_cmd,
	input  logic       push_ready,
	// remote pull command and sideband status
	output logic       pull_valid,
	output cdde_pull_s pull_cmd,
	input  logic       pull_ready,
	input  logic [1:0] rmt_status,
	// processor interrupts
	output logic       done_irq,
	output logic       err_irq
);
	localparam int QW = $clog2(CH_DEPTH);
	localparam int SW = $clog2(SIGN_DEPTH);

	typedef enum {S_IDLE, S_FETCH, S_DECODE, S_PUSH, S_PULL, S_PWAIT,
		S_FIN} cdde_state_e;

	cdde_state_e    st_q;                   // engine state
	logic [1:0]     ctl_q;                  // interrupt enables
	logic           err_pend_q;             // sticky pull abort flag
	logic [31:0]    rdata_q;                // registered read data
	logic [63:0]    w_q [3];                // words 0..2 of descriptor
	logic [1:0]     beat_q;                 // fetch word index
	logic [25:0]    ptr_q;                  // descriptor pointer 29:4
	logic [3:0]     ch_q;                   // channel being served
	logic [2:0]     rr_q;                   // last round robin channel
	logic [15:0]    act_q;                  // chain in flight per channel
	logic [25:0]    nxt_q [16];             // next pointer per channel
	logic [25:0]    cq_mem [16][CH_DEPTH];  // start address queues
	logic [QW:0]    cq_cnt [16];            // queue fill levels
	logic [QW-1:0]  cq_rp  [16];            // queue read pointers
	logic [QW-1:0]  cq_wp  [16];            // queue write pointers
	logic [31:0]    src_q, dst_q;           // push segment addresses
	logic [15:0]    rem_q;                  // words left in descriptor
	logic           fin_err_q;              // abort flag for finish
	cdde_sign_s     sg_mem [SIGN_DEPTH];    // completion queue
	logic [SW-1:0]  sg_wp_q, sg_rp_q;       // completion pointers
	logic [SW:0]    sg_cnt_q;               // completion fill level
	logic [1:0]     rs1_q, rs2_q, rs3_q;    // sideband synchroniser

	// register decode
	logic        start_wr;
	logic [3:0]  start_ch;
	logic        sign_rd;
	logic        sg_ne;
	assign start_wr = bus.wr && bus.addr[11:6] == REG_START[11:6];
	assign start_ch = bus.addr[5:2];
	assign sg_ne    = sg_cnt_q != '0;
	assign sign_rd  = bus.rd && bus.addr == REG_SIGN;

	// pick the next channel: fixed high half first, then rotation
	function automatic logic [4:0] pick(input logic [15:0] p,
		input logic [2:0] last);
		logic [4:0] r;
		logic [2:0] k;
		r = '0;
		for (int i = 8; i < 16; i++) begin
			if (p[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		if (!r[4]) begin
			for (int j = 8; j >= 1; j--) begin
				k = last + 3'(j);
				if (p[{1'b0, k}]) begin
					r = {1'b1, 1'b0, k};
				end
			end
		end
		return r;
	endfunction

	// words a push segment may carry before the destination boundary
	function automatic logic [15:0] seg_len(input logic [31:0] dst,
		input logic [15:0] rem, input logic [1:0] sel);
		logic [12:0] b;
		logic [12:0] room;
		case (sel)
			2'h1:    b = BND_256;
			2'h2:    b = BND_2K;
			2'h3:    b = BND_4K;
			default: b = '0;
		endcase
		room = b - (dst[12:0] & (b - 13'h0001));
		if (b == '0 || {5'h00, room[12:2]} >= rem) begin
			return rem;
		end
		return {5'h00, room[12:2]};
	endfunction

	// per-channel pending state and the pick for this boundary
	logic [15:0] pend;
	logic [4:0]  pk;
	logic        take;
	generate
		for (genvar c = 0; c < 16; c++) begin : g_pend
			assign pend[c] = act_q[c] || cq_cnt[c] != '0;
		end
	endgenerate
	assign pk   = pick(pend, rr_q);
	assign take = st_q == S_IDLE && pk[4];

	// start queues: written by software, popped by the scheduler
	generate
		for (genvar c = 0; c < 16; c++) begin : g_cq
			logic pu, po;
			// a full queue drops the write; software bounds the load
			assign pu = start_wr && start_ch == 4'(c) &&
				cq_cnt[c] != (QW+1)'(CH_DEPTH);
			assign po = take && pk[3:0] == 4'(c) && !act_q[c];
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					cq_cnt[c] <= '0;
					cq_rp[c]  <= '0;
					cq_wp[c]  <= '0;
				end else begin
					cq_cnt[c] <= cq_cnt[c] + (QW+1)'(pu) - (QW+1)'(po);
					if (pu) begin
						cq_wp[c] <= cq_wp[c] + 1'b1;
					end
					if (po) begin
						cq_rp[c] <= cq_rp[c] + 1'b1;
					end
				end
			end
			// queue storage, no reset needed
			always_ff @(posedge clk) begin
				if (pu) begin
					cq_mem[c][cq_wp[c]] <= bus.wdata[29:4];
				end
			end
		end
	endgenerate

	// control register and sticky abort flag
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_q      <= CTL_RST;
			err_pend_q <= 1'b0;
		end else begin
			if (bus.wr && bus.addr == REG_CTL) begin
				ctl_q <= bus.wdata[1:0];
			end
			// a new abort wins over a clear in the same cycle
			if (st_q == S_FIN && fin_err_q) begin
				err_pend_q <= 1'b1;
			end else if (bus.wr && bus.addr == REG_STAT &&
				bus.wdata[STAT_ERR]) begin
				err_pend_q <= 1'b0;
			end
		end
	end

	// read data, valid the cycle after the strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= '0;
		end else if (bus.rd) begin
			case (bus.addr)
				REG_CTL:  rdata_q <= {30'h0000_0000, ctl_q};
				// pending mask on top, abort flag and busy at the bottom
				REG_STAT: rdata_q <= {pend, 14'h0000, err_pend_q,
					st_q != S_IDLE};
				// empty read returns a stale entry with the flag low
				REG_SIGN: rdata_q <= {16'h0000, sg_ne, 3'h0,
					sg_mem[sg_rp_q]};
				default:  rdata_q <= '0;
			endcase
		end
	end
	assign rdata = rdata_q;

	// sideband status: three stages, accepted once two agree
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rs1_q <= '0;
			rs2_q <= '0;
			rs3_q <= '0;
		end else begin
			rs1_q <= rmt_status;
			rs2_q <= rs1_q;
			rs3_q <= rs2_q;
		end
	end
	logic rs_ok;
	assign rs_ok = rs2_q == rs3_q;

	// completion queue: overflow silently wraps
	logic       sg_wr;
	logic       sg_po;
	cdde_sign_s sg_in;
	assign sg_wr = st_q == S_FIN && (fin_err_q || !w_q[2][W2_NXT]);
	assign sg_po = sign_rd && sg_ne;
	assign sg_in = '{sub: w_q[1][W1_SUB_LO+:4], err: fin_err_q,
		sig: w_q[2][W2_SIG_LO+:7]};
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sg_wp_q  <= '0;
			sg_rp_q  <= '0;
			sg_cnt_q <= '0;
		end else begin
			sg_cnt_q <= sg_cnt_q + (SW+1)'(sg_wr) - (SW+1)'(sg_po);
			if (sg_wr) begin
				sg_wp_q <= sg_wp_q + 1'b1;
			end
			if (sg_po) begin
				sg_rp_q <= sg_rp_q + 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (sg_wr) begin
			sg_mem[sg_wp_q] <= sg_in;
		end
	end
	assign done_irq = sg_ne && ctl_q[CTL_DONE_IE];
	assign err_irq  = err_pend_q && ctl_q[CTL_ERR_IE];

	// descriptor fetch: four words at eight-byte steps
	assign mem_req  = st_q == S_FETCH;
	assign mem_addr = {2'h0, ptr_q, 4'h0} +
		WORD_STEP * {30'h0000_0000, beat_q};

	// push segment, split at the selected boundary
	logic [15:0] seg;
	assign seg = seg_len(dst_q, rem_q, w_q[2][W2_BND_LO+:2]);
	assign push_valid     = st_q == S_PUSH;
	assign push_cmd.src   = src_q;
	assign push_cmd.dst   = dst_q;
	assign push_cmd.words = seg;
	assign push_cmd.dbl   = w_q[2][W2_DBL];
	assign push_cmd.snoop = w_q[2][W2_SNP];

	// remote pull command built straight from the descriptor
	assign pull_valid     = st_q == S_PULL;
	assign pull_cmd.hdr   = w_q[0][63:32];
	assign pull_cmd.raddr = w_q[0][31:0];
	assign pull_cmd.waddr = w_q[1][31:0];
	assign pull_cmd.words = w_q[1][W1_CNT_LO+:16];
	// burst decoded apart so the command has one kind of driver
	logic [6:0] burst;
	always_comb begin
		case (w_q[1][W1_MAX_LO+:2])
			2'h3:    burst = BURST_64;
			2'h2:    burst = BURST_32;
			2'h1:    burst = BURST_15;
			default: burst = BURST_8;
		endcase
	end
	assign pull_cmd.burst = burst;
	assign pull_cmd.hold = w_q[1][W1_HOLD];
	assign pull_cmd.tgt  = w_q[1][W1_DST_LO+:2];
	assign pull_cmd.io   = w_q[1][W1_TYPE];
	assign pull_cmd.wsnp = w_q[1][W1_WSNP];
	assign pull_cmd.dsz  = w_q[1][W1_DSZ];

	// main sequencer, one descriptor per pass through idle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q      <= S_IDLE;
			beat_q    <= '0;
			ptr_q     <= '0;
			ch_q      <= '0;
			fin_err_q <= 1'b0;
			src_q     <= '0;
			dst_q     <= '0;
			rem_q     <= '0;
		end else begin
			case (st_q)
				S_IDLE: if (take) begin
					ch_q      <= pk[3:0];
					beat_q    <= '0;
					fin_err_q <= 1'b0;
					// resume a chain or start a queued one
					ptr_q <= act_q[pk[3:0]] ? nxt_q[pk[3:0]] :
						cq_mem[pk[3:0]][cq_rp[pk[3:0]]];
					st_q <= S_FETCH;
				end
				S_FETCH: if (mem_ack) begin
					beat_q <= beat_q + 1'b1;
					// word three is read and dropped
					if (beat_q == 2'h3) begin
						st_q <= S_DECODE;
					end
				end
				S_DECODE: begin
					src_q <= w_q[1][31:0];
					dst_q <= w_q[0][31:0];
					rem_q <= w_q[1][W1_CNT_LO+:16];
					if (w_q[2][W2_RMT]) begin
						st_q <= S_PULL;
					end else if (w_q[1][W1_CNT_LO+:16] == '0) begin
						// zero count is illegal; end it without a move
						st_q <= S_FIN;
					end else begin
						st_q <= S_PUSH;
					end
				end
				S_PUSH: if (push_ready) begin
					src_q <= src_q + {14'h0000, seg, 2'h0};
					dst_q <= dst_q + {14'h0000, seg, 2'h0};
					rem_q <= rem_q - seg;
					// posted writes: no abort path
					if (rem_q == seg) begin
						st_q <= S_FIN;
					end
				end
				S_PULL: if (pull_ready) begin
					st_q <= S_PWAIT;
				end
				S_PWAIT: if (rs_ok && rs3_q == RS_DONE) begin
					st_q <= S_FIN;
				end else if (rs_ok && rs3_q == RS_ERR) begin
					fin_err_q <= 1'b1;
					st_q      <= S_FIN;
				end
				S_FIN: st_q <= S_IDLE;
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// fetched words
	always_ff @(posedge clk) begin
		if (st_q == S_FETCH && mem_ack && beat_q != 2'h3) begin
			w_q[beat_q] <= mem_data;
		end
	end

	// chain tracking per channel and the rotation point
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			act_q <= '0;
			rr_q  <= 3'h7;
			for (int c = 0; c < 16; c++) begin
				nxt_q[c] <= '0;
			end
		end else if (st_q == S_FIN) begin
			// an abort ends the chain whatever the link says
			act_q[ch_q] <= w_q[2][W2_NXT] && !fin_err_q;
			nxt_q[ch_q] <= w_q[2][W2_PTR_LO+:26];
			if (!ch_q[3]) begin
				rr_q <= ch_q[2:0];
			end
		end
	end

	// checks
	fetch_align_a: assert property (@(posedge clk) disable iff (!rst_b)
		mem_req |-> mem_addr[31:30] == 2'h0 && mem_addr[2:0] == 3'h0)
		else $error("fetch address out of range");
	high_first_a: assert property (@(posedge clk) disable iff (!rst_b)
		take && |pend[15:8] |->
		pk[3] && (pend[15:8] >> pk[2:0]) == 8'h01)
		else $error("high channel not preferred");
	rr_order_a: assert property (@(posedge clk) disable iff (!rst_b)
		take && !(|pend[15:8]) && pend[3'(rr_q + 3'h1)] |->
		pk[3:0] == {1'b0, 3'(rr_q + 3'h1)})
		else $error("rotation skipped a channel");
	seg_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
		push_valid && w_q[2][38:37] == 2'h1 |->
		{8'h00, dst_q[7:0]} + {seg[13:0], 2'h0} <= 16'h0100)
		else $error("segment crosses boundary");
	seg_nonzero_a: assert property (@(posedge clk) disable iff (!rst_b)
		push_valid |-> push_cmd.words != '0 && push_cmd.words <= rem_q)
		else $error("bad segment length");
	burst_map_a: assert property (@(posedge clk) disable iff (!rst_b)
		pull_valid && w_q[1][47:46] == 2'h1 |-> pull_cmd.burst == 7'h0F)
		else $error("burst size mismatch");
	abort_sign_a: assert property (@(posedge clk) disable iff (!rst_b)
		st_q == S_PWAIT && rs_ok && rs3_q == RS_ERR |=>
		sg_wr && sg_in.err ##1 !act_q[$past(ch_q, 2)])
		else $error("abort not signed");
	sign_count_a: assert property (@(posedge clk) disable iff (!rst_b)
		sg_wr && !sg_po && ctl_q[0] |=>
		sg_cnt_q == $past(sg_cnt_q) + 1'b1 && done_irq)
		else $error("completion not queued");
	fetch_beats_a: assert property (@(posedge clk) disable iff (!rst_b)
		st_q == S_IDLE && take |=> mem_req && beat_q == 2'h0)
		else $error("fetch did not start");
	start_q_a: assert property (@(posedge clk) disable iff (!rst_b)
		start_wr && cq_cnt[start_ch] == '0 |=>
		pend[$past(start_ch)])
		else $error("start not queued");
endmodule

//--- cdde_pkg.sv
// shared constants and carrier types for the chained descriptor engine
package cdde_pkg;
	// register offsets, low address bits of the register port
	localparam int          ADDR_W     = 12;
	localparam logic [11:0] REG_CTL    = 12'h0300;
	localparam logic [11:0] REG_STAT   = 12'h0304;
	localparam logic [11:0] REG_SIGN   = 12'h0340;
	localparam logic [11:0] REG_START  = 12'h03C0;
	// control and status bit positions
	localparam int          CTL_DONE_IE = 0;
	localparam int          CTL_ERR_IE  = 1;
	localparam logic [1:0]  CTL_RST     = 2'h0;
	localparam int          STAT_BUSY   = 0;
	localparam int          STAT_ERR    = 1;
	localparam int          SIGN_NE     = 15;
	// descriptor field positions
	localparam int W1_CNT_LO  = 48;
	localparam int W1_MAX_LO  = 46;
	localparam int W1_HOLD    = 45;
	localparam int W1_DST_LO  = 43;
	localparam int W1_TYPE    = 42;
	localparam int W1_WSNP    = 41;
	localparam int W1_DSZ     = 40;
	localparam int W1_SUB_LO  = 36;
	localparam int W2_SIG_LO  = 48;
	localparam int W2_RMT     = 39;
	localparam int W2_BND_LO  = 37;
	localparam int W2_DBL     = 36;
	localparam int W2_SNP     = 33;
	localparam int W2_NXT     = 32;
	localparam int W2_PTR_LO  = 4;
	// remote status line codes
	localparam logic [1:0] RS_DONE = 2'h1;
	localparam logic [1:0] RS_ERR  = 2'h2;
	// read burst sizes in words, and boundary sizes in bytes
	localparam logic [6:0]  BURST_64 = 7'h40;
	localparam logic [6:0]  BURST_32 = 7'h20;
	localparam logic [6:0]  BURST_15 = 7'h0F;
	localparam logic [6:0]  BURST_8  = 7'h08;
	localparam logic [12:0] BND_256  = 13'h0100;
	localparam logic [12:0] BND_2K   = 13'h0800;
	localparam logic [12:0] BND_4K   = 13'h1000;
	localparam logic [31:0] WORD_STEP = 32'h0000_0008;

	// register port request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} cdde_bus_s;

	// one memory push segment for a transfer bridge
	typedef struct packed {
		logic [31:0] src;
		logic [31:0] dst;
		logic [15:0] words;
		logic        dbl;
		logic        snoop;
	} cdde_push_s;

	// remote pull command for the backplane bridge
	typedef struct packed {
		logic [31:0] hdr;
		logic [31:0] raddr;
		logic [31:0] waddr;
		logic [15:0] words;
		logic [6:0]  burst;
		logic        hold;
		logic [1:0]  tgt;
		logic        io;
		logic        wsnp;
		logic        dsz;
	} cdde_pull_s;

	// completion entry, laid out as the read port's low bits
	typedef struct packed {
		logic [3:0] sub;
		logic       err;
		logic [6:0] sig;
	} cdde_sign_s;
endpackage

//--- cdde_far.sv
// far-side model: descriptor memory, push bridge and remote pull machine
`timescale 1ns/1ps
module cdde_far
	import cdde_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// descriptor fetch
	input  wire logic        mem_req,
	input  wire logic [31:0] mem_addr,
	output logic             mem_ack,
	output logic [63:0]      mem_data,
	// push and pull bridges
	input  wire logic        push_valid,
	input  cdde_push_s       push_cmd,
	output logic             push_ready,
	input  wire logic        pull_valid,
	input  cdde_pull_s       pull_cmd,
	output logic             pull_ready,
	output logic [1:0]       rmt_status
);
	logic [63:0] mem [0:255];  // descriptor store, filled by the bench
	int          slow = 0;     // wait cycles before each answer
	logic        pull_err = 0; // pulls end in a backplane error
	cdde_push_s  push_q [$];   // segments taken
	cdde_pull_s  pull_q [$];   // pull commands taken
	int          wait_q;       // cycles waited on a fetch beat
	int          pw_q;         // cycles a push has waited
	int          lw_q;         // cycles a pull has waited
	int          rs_q;         // cycles since a pull was taken
	logic [63:0] last_q;       // last word, inverted while idle

	// idle bus shows no stale word, so the engine cannot live on luck
	assign mem_data   = mem_ack ? mem[mem_addr[10:3]] : ~last_q;
	assign push_ready = (pw_q >= slow);
	assign pull_ready = (lw_q >= slow);
	// status code held six cycles, well past the two the engine needs
	assign rmt_status = (rs_q >= 4 && rs_q < 10) ?
		(pull_err ? RS_ERR : RS_DONE) : 2'h0;

	// one beat answered per request after the chosen delay
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_ack <= 1'b0;
			wait_q  <= 0;
			last_q  <= '0;
		end else if (mem_ack) begin
			mem_ack <= 1'b0;
			last_q  <= mem_data;
		end else if (mem_req) begin
			mem_ack <= (wait_q >= slow);
			wait_q  <= (wait_q >= slow) ? 0 : wait_q + 1;
		end
	end

	// bridges record what they take; pull starts the status sequence
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pw_q <= 0;
			lw_q <= 0;
			rs_q <= 0;
		end else begin
			if (push_valid && push_ready) begin
				pw_q <= 0;
				push_q.push_back(push_cmd);
			end else if (push_valid)
				pw_q <= pw_q + 1;
			if (pull_valid && pull_ready) begin
				lw_q <= 0;
				pull_q.push_back(pull_cmd);
			end else if (pull_valid)
				lw_q <= lw_q + 1;
			if (pull_valid && pull_ready)
				rs_q <= 1;
			else
				rs_q <= (rs_q != 0 && rs_q < 12) ? rs_q + 1 : 0;
		end
	end
endmodule

//--- cdde_engine_tb.sv
// self-checking bench for the chained descriptor engine
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module cdde_engine_tb
	import cdde_pkg::*;
;
	localparam logic [31:0] HDR = 32'hC188_0100;
	// design signals
	logic        clk;
	logic        rst_b;
	cdde_bus_s   bus;
	logic [31:0] rdata;
	logic        mem_req;
	logic [31:0] mem_addr;
	logic        mem_ack;
	logic [63:0] mem_data;
	logic        push_valid;
	cdde_push_s  push_cmd;
	logic        push_ready;
	logic        pull_valid;
	cdde_pull_s  pull_cmd;
	logic        pull_ready;
	logic [1:0]  rmt_status;
	logic        done_irq;
	logic        err_irq;
	// bookkeeping
	int          failures = 0;
	int          n_tests  = 0;
	int          cyc      = 0;

	cdde_engine dut (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
		.mem_data(mem_data), .push_valid(push_valid), .push_cmd(push_cmd),
		.push_ready(push_ready), .pull_valid(pull_valid),
		.pull_cmd(pull_cmd), .pull_ready(pull_ready),
		.rmt_status(rmt_status), .done_irq(done_irq), .err_irq(err_irq));
	cdde_far far (.clk(clk), .rst_b(rst_b), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data),
		.push_valid(push_valid), .push_cmd(push_cmd),
		.push_ready(push_ready), .pull_valid(pull_valid),
		.pull_cmd(pull_cmd), .pull_ready(pull_ready),
		.rmt_status(rmt_status));

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// hang guard, far above the expected run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// one-cycle register strobes, read data one cycle later
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk) bus <= '{1'b1, 1'b0, a, d};
		@(posedge clk) bus <= '0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk) bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
		@(posedge clk) bus <= '0;
		#1 d = rdata;
	endtask
	task automatic start(input int ch, input int a);
		wr(REG_START + 12'(4 * ch), 32'(a) << 3);
	endtask
	// idle once busy stays low and no remote status is in flight
	task automatic idle();
		logic [31:0] s;
		int          k;
		k = 0;
		for (int i = 0; i < 3000 && k < 4; i++) begin
			rd(REG_STAT, s);
			k = (s[STAT_BUSY] === 1'b0 && far.rs_q == 0) ? k + 1 : 0;
		end
		`CHK("idle", 1'b1, k == 4)
	endtask

	// word two with reserved bits set, pointer taken from a word index
	function automatic logic [63:0] w2(logic [6:0] sg, logic rm,
		logic [1:0] bd, logic db, logic sn, logic nx, int a);
		return {9'h1FF, sg, 8'hFF, rm, bd, db, 2'h3, sn, nx, 32'(a) << 3};
	endfunction
	function automatic logic [31:0] ent(logic [3:0] sb, logic er,
		logic [6:0] sg);
		return {16'h0000, 1'b1, 3'b000, sb, er, sg};
	endfunction
	// word three is all ones: the engine must not care
	task automatic put(int a, logic [63:0] x0, x1, x2);
		far.mem[a] = x0;
		far.mem[a + 1] = x1;
		far.mem[a + 2] = x2;
		far.mem[a + 3] = '1;
	endtask
	// short push element of eight words
	task automatic pp(int a, logic [6:0] sg, logic nx, int na);
		put(a, {32'h0, 32'h4000_0000 + 32'(a)},
			{16'h0008, 8'h0, 4'h0, 4'h0, 32'h0000_4000},
			w2(sg, 1'b0, 2'h0, 1'b0, 1'b0, nx, na));
	endtask

	// reset state, empty completion read, unmapped read
	task automatic t_regs();
		logic [31:0] v;
		rd(REG_SIGN, v);
		`CHK("empty flag", 1'b0, v[SIGN_NE])
		rd(12'h00FC, v);
		`CHK("unmapped", 32'h0000_0000, v)
		`CHK("irq idle", 2'b00, {done_irq, err_irq})
		$display("test regs done");
	endtask

	// every boundary code, with buffer merge and snoop flags
	task automatic t_push();
		logic [31:0] v;
		logic [15:0] sm;
		logic [15:0] f [4] = '{16'h0300, 16'h0002, 16'h0002, 16'h0202};
		logic [15:0] s [4] = '{16'h0000, 16'h0040, 16'h0200, 16'h00FE};
		wr(REG_CTL, 32'h0000_0001);
		far.slow = 1;
		for (int k = 0; k < 4; k++) begin
			put(16, {32'hA5A5_A5A5, 32'h2000_07F8},
				{16'h0300, 8'hFF, 4'(k), 4'hF, 32'h0000_4000},
				w2(7'(16 + k), 1'b0, 2'(k), k[0], k[1], 1'b0, 0));
			far.push_q.delete();
			start(k, 16);
			idle();
			`CHK("seg0", {32'h0000_4000, 32'h2000_07F8, f[k], k[0], k[1]},
				far.push_q[0])
			sm = 0;
			foreach (far.push_q[j])
				sm += far.push_q[j].words;
			`CHK("word sum", 16'h0300, sm)
			if (k != 0)
				`CHK("seg1", {32'h4000 + 32'(f[k]) * 4, s[k]},
					{far.push_q[1].src, far.push_q[1].words})
			`CHK("done irq", 1'b1, done_irq)
			rd(REG_SIGN, v);
			`CHK("entry", ent(4'(k), 1'b0, 7'(16 + k)), v)
			`CHK("irq drop", 1'b0, done_irq)
		end
		$display("test push done");
	endtask

	// every burst size, targets 0 to 2, then an aborted chain
	task automatic t_pull();
		logic [31:0] v;
		logic [6:0]  b [4] = '{BURST_8, BURST_15, BURST_32, BURST_64};
		cdde_pull_s  e;
		far.slow = 2;
		for (int k = 0; k < 4; k++) begin
			e = '{HDR, 32'h8000_0000 + k, 32'h3000_0000 + k * 16,
				16'h0010 + k, b[k], k[0], 2'(k % 3), k[1], ~k[0], k[0]};
			put(32, {e.hdr, e.raddr}, {e.words, 2'(k), e.hold, e.tgt, e.io,
				e.wsnp, e.dsz, 4'(k), 4'hF, e.waddr},
				w2(7'(32 + k), 1'b1, 2'h3, 1'b1, 1'b1, 1'b0, 0));
			far.pull_q.delete();
			start(8 + k, 32);
			idle();
			`CHK("pull cmd", e, far.pull_q[0])
			rd(REG_SIGN, v);
			`CHK("entry", ent(4'(k), 1'b0, 7'(32 + k)), v)
		end
		// backplane error on the first of two linked pulls
		far.pull_err = 1;
		put(36, {HDR, 32'h8000_0000}, {16'h0004, 8'h00, 4'h0, 4'hF,
			32'h3000_0000}, w2(7'h24, 1'b1, 2'h3, 1'b1, 1'b1, 1'b1, 40));
		put(40, {HDR, 32'h8000_0000}, {16'h0004, 8'h00, 4'h0, 4'hF,
			32'h3000_0000}, w2(7'h28, 1'b1, 2'h3, 1'b1, 1'b1, 1'b0, 0));
		far.pull_q.delete();
		wr(REG_CTL, 32'h0000_0003);
		start(1, 36);
		idle();
		far.pull_err = 0;
		`CHK("abort", 1, far.pull_q.size())
		`CHK("err irq", 1'b1, err_irq)
		rd(REG_STAT, v);
		`CHK("err stat", 1'b1, v[STAT_ERR])
		`CHK("no pending", 16'h0000, v[31:16])
		rd(REG_SIGN, v);
		`CHK("err entry", ent(4'h0, 1'b1, 7'h24), v)
		wr(REG_STAT, 32'h0000_0002);
		#1 `CHK("err clear", 1'b0, err_irq)
		$display("test pull done");
	endtask

	// fixed priority pre-empts only at an element boundary
	task automatic t_prio();
		logic [31:0] v;
		logic [6:0]  o [4] = '{7'h0F, 7'h08, 7'h04, 7'h02};
		far.slow = 3;
		far.push_q.delete();
		pp(48, 7'h01, 1'b1, 52);
		pp(52, 7'h02, 1'b0, 0);
		pp(56, 7'h0F, 1'b0, 0);
		pp(60, 7'h08, 1'b0, 0);
		pp(64, 7'h04, 1'b0, 0);
		start(3, 48);
		start(15, 56);
		start(8, 60);
		start(4, 64);
		idle();
		`CHK("first push", 32'h4000_0030, far.push_q[0].dst)
		`CHK("next elem", 32'h4000_0034, far.push_q[4].dst)
		for (int i = 0; i < 4; i++) begin
			rd(REG_SIGN, v);
			`CHK("order", ent(4'h0, 1'b0, o[i]), v)
		end
		$display("test prio done");
	endtask

	// ten starts into channel 5 while channel 15 is busy: eight queue, two drop
	task automatic t_depth();
		logic [31:0] v;
		far.slow = 40;
		pp(68, 7'h7F, 1'b0, 0);
		pp(72, 7'h55, 1'b0, 0);
		start(15, 68);
		for (int i = 0; i < 10; i++)
			start(5, 72);
		far.slow = 0;
		idle();
		for (int i = 0; i < 9; i++) begin
			rd(REG_SIGN, v);
			`CHK("queued", ent(4'h0, 1'b0, i == 0 ? 7'h7F : 7'h55), v)
		end
		rd(REG_SIGN, v);
		`CHK("drained", 1'b0, v[SIGN_NE])
		$display("test depth done");
	endtask

	// main sequence
	initial begin
		bus = '0;
		rst_b = 1'b0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_push();
		t_pull();
		t_prio();
		t_depth();
		print_verdict();
	end
endmodule
